// File: rtl/wwdt_top.sv
// Windowed watchdog with AHB-Lite registers, wake and device reset
//
// Notes on behaviour
// - Counter advances only when enabled by config strap or software bit.
// - In run mode the tick is the low-power RC clock or user clock.
// - In sleep or idle the tick is always the low-power RC clock.
// - Counter reaching the period end in run mode issues a device reset.
// - Windowed or non-windowed mode chosen by configuration.
// - A selectable postscaler sets the period length.
// - Separate postscalers apply in run and in sleep or idle.
// - Expiry in sleep or idle wakes the device.
// - A watchdog reset sets the watchdog_reset_flag in reset_cause_register.
// - A system clock switch does not clear the counter.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
module wwdt_top
  import wwdt_pkg::*;
(
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  // AHB-Lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic [31:0]      O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // Watchdog clock sources, configuration and power state
  input  wire logic        I_LOW_POWER_RC_CLOCK_CLK,
  input  wire logic        I_USER_CLK,
  input  wire logic        I_CFG_EN,
  input  wire logic        I_CFG_WIN,
  input  wire logic        I_SLEEP,
  input  wire logic        I_CLK_SWITCH,
  // Device outputs
  output logic             O_DEV_RESET,
  output logic             O_WAKE,
  output logic             O_IRQ
);
  logic low_power_rc_clock_tick;
  logic user_tick;

  // Both sources synchronised; each is a foreign clock
  wwdt_tick_sync u_low_power_rc_clock (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_src   (I_LOW_POWER_RC_CLOCK_CLK),
    .o_tick  (low_power_rc_clock_tick)
  );
  wwdt_tick_sync u_user (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_src   (I_USER_CLK),
    .o_tick  (user_tick)
  );

  // Pin synchronisers for config and power inputs
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {I_SLEEP, I_CFG_WIN, I_CFG_EN};
      pin_sync_r <= pin_meta_r;
    end
  end
  logic cfg_en;
  logic cfg_win;
  logic sleep;
  assign cfg_en  = pin_sync_r[0];
  assign cfg_win = pin_sync_r[1];
  assign sleep   = pin_sync_r[2];

  function automatic logic [CNT_W-1:0] ps_limit(input logic [PS_W-1:0] ps);
    ps_limit = CNT_W'(1) << ps;
  endfunction

  // Bus address phase capture
  logic        ap_wr_r;
  logic        ap_rd_r;
  logic [7:0]  ap_addr_r;
  logic        ap_wr_nxt;
  logic        ap_rd_nxt;
  logic [7:0]  ap_addr_nxt;
  logic        ap_valid;
  assign ap_valid = I_HSEL & I_HREADY & I_HTRANS[1];

  always_comb begin
    ap_wr_nxt   = ap_valid & I_HWRITE;
    ap_rd_nxt   = ap_valid & ~I_HWRITE;
    ap_addr_nxt = ap_valid ? I_HADDR[7:0] : ap_addr_r;
  end

  // Register state
  logic [7:0]      ctrl_r,   ctrl_nxt;
  logic [PS_W-1:0] ps_run_r, ps_run_nxt;
  logic [PS_W-1:0] ps_slp_r, ps_slp_nxt;
  logic [EV_W-1:0] stat_r,   stat_nxt;
  logic [EV_W-1:0] mask_r,   mask_nxt;
  logic            rflag_r,  rflag_nxt;
  logic [31:0]     rdata_r,  rdata_nxt;
  logic            irq_r,    irq_nxt;
  logic [CNT_W-1:0] cnt_r,   cnt_nxt;
  logic [7:0]      pulse_r,  pulse_nxt;
  logic            dev_rst_r, dev_rst_nxt;
  logic            wake_r,   wake_nxt;
  wwdt_state_t     st_r,     st_nxt;

  logic            wd_en;
  logic            win_mode;
  logic            tick;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] win_open;
  logic            clr_cmd;
  logic            early;
  logic            expire;
  logic [EV_W-1:0] ev;

  assign wd_en    = cfg_en | ctrl_r[CTRL_SW_EN_BIT];
  assign win_mode = cfg_win | ctrl_r[CTRL_WIN_BIT];
  // Sleep forces the RC tick regardless of run selection
  assign tick = sleep ? low_power_rc_clock_tick
              : (ctrl_r[CTRL_CLKSEL_BIT] ? user_tick : low_power_rc_clock_tick);
  assign limit = ps_limit(sleep ? ps_slp_r : ps_run_r);
  // Window opens after 1/2,3/4,7/8 or 15/16 of the period per selector
  // Widened first so selector 3 gives a shift of 4, not a wrapped 0
  assign win_open = limit - (limit >> (3'(ctrl_r[CTRL_WINSEL_LSB +: WINSEL_W]) + 3'd1));
  assign clr_cmd  = ap_wr_r & (ap_addr_r == CLEAR_OFS) & (I_HWDATA[15:0] == CLEAR_KEY);
  assign early    = clr_cmd & wd_en & win_mode & (cnt_r < win_open) & (st_r == ST_RUN);
  assign expire   = wd_en & tick & (cnt_r >= limit - 1'b1) & (st_r == ST_RUN);
  assign ev       = {expire & sleep, early, expire};

  // Register and bus logic
  always_comb begin
    ctrl_nxt   = ctrl_r;
    ps_run_nxt = ps_run_r;
    ps_slp_nxt = ps_slp_r;
    mask_nxt   = mask_r;
    stat_nxt   = stat_r;
    rflag_nxt  = rflag_r;
    rdata_nxt  = 32'h0000_0000;
    if (ap_wr_r) begin
      unique case (ap_addr_r)
        CTRL_OFS: ctrl_nxt = I_HWDATA[7:0];
        PERIOD_OFS: begin
          ps_run_nxt = I_HWDATA[PERIOD_RUN_LSB +: PS_W];
          ps_slp_nxt = I_HWDATA[PERIOD_SLP_LSB +: PS_W];
        end
        MASK_OFS:   mask_nxt  = I_HWDATA[EV_W-1:0];
        RCAUSE_OFS: rflag_nxt = rflag_r & ~I_HWDATA[RCAUSE_WDT_BIT];
        default: ;
      endcase
    end
    if (ap_valid & ~I_HWRITE) begin
      unique case (I_HADDR[7:0])
        CTRL_OFS:   rdata_nxt = {24'h0, ctrl_r};
        PERIOD_OFS: rdata_nxt = {19'h0, ps_slp_r, 3'h0, ps_run_r};
        RCAUSE_OFS: rdata_nxt = {31'h0, rflag_r};
        STATUS_OFS: rdata_nxt = {29'h0, stat_r};
        MASK_OFS:   rdata_nxt = {29'h0, mask_r};
        COUNT_OFS:  rdata_nxt = cnt_r;
        default:    rdata_nxt = 32'h0000_0000;
      endcase
    end
    // Read clears status; a new event wins over the clear
    if (ap_rd_r & (ap_addr_r == STATUS_OFS)) begin
      stat_nxt = '0;
    end
    stat_nxt = stat_nxt | ev;
    if (st_r == ST_FIRE) begin
      rflag_nxt = 1'b1;
    end
    irq_nxt = |(stat_nxt & mask_r);
  end

  // Counter and reset sequencing
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    pulse_nxt   = pulse_r;
    dev_rst_nxt = 1'b0;
    wake_nxt    = 1'b0;
    unique case (st_r)
      ST_RUN: begin
        // Clock switch input is deliberately ignored here
        if (!wd_en || clr_cmd) begin
          cnt_nxt = '0;
        end else if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
        if (early || (expire && !sleep)) begin
          st_nxt    = ST_FIRE;
          pulse_nxt = 8'(RST_PULSE_CYC);
        end else if (expire && sleep) begin
          wake_nxt = 1'b1;
          cnt_nxt  = '0;
        end
      end
      ST_FIRE: begin
        dev_rst_nxt = 1'b1;
        cnt_nxt     = '0;
        pulse_nxt   = pulse_r - 8'h01;
        if (pulse_r == 8'h01) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        st_nxt = ST_RUN;
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ap_wr_r   <= 1'b0;
      ap_rd_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      ctrl_r    <= CTRL_RST;
      ps_run_r  <= PS_RUN_RST;
      ps_slp_r  <= PS_SLP_RST;
      stat_r    <= '0;
      mask_r    <= MASK_RST;
      rflag_r   <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      irq_r     <= 1'b0;
      cnt_r     <= '0;
      pulse_r   <= 8'h00;
      dev_rst_r <= 1'b0;
      wake_r    <= 1'b0;
      st_r      <= ST_RUN;
    end else begin
      ap_wr_r   <= ap_wr_nxt;
      ap_rd_r   <= ap_rd_nxt;
      ap_addr_r <= ap_addr_nxt;
      ctrl_r    <= ctrl_nxt;
      ps_run_r  <= ps_run_nxt;
      ps_slp_r  <= ps_slp_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      rflag_r   <= rflag_nxt;
      rdata_r   <= rdata_nxt;
      irq_r     <= irq_nxt;
      cnt_r     <= cnt_nxt;
      pulse_r   <= pulse_nxt;
      dev_rst_r <= dev_rst_nxt;
      wake_r    <= wake_nxt;
      st_r      <= st_nxt;
    end
  end

  assign O_HRDATA    = rdata_r;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign O_DEV_RESET = dev_rst_r;
  assign O_WAKE      = wake_r;
  assign O_IRQ       = irq_r;

  // Checks
  sequence s_fire;
    st_r == ST_FIRE;
  endsequence

  a_expire_reset: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    expire && !sleep |=> s_fire ##1 O_DEV_RESET)
    else $error("expiry did not raise device reset");
  a_early_reset: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    early |=> s_fire ##1 O_DEV_RESET)
    else $error("early clear did not raise device reset");
  a_disabled_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !wd_en && st_r == ST_RUN |=> cnt_r == 0)
    else $error("counter moved while disabled");
  a_clear_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    clr_cmd && !early && st_r == ST_RUN |=> cnt_r == 0)
    else $error("clear did not restart counter");
  a_sleep_wake: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    expire && sleep && !early |=> O_WAKE && !O_DEV_RESET)
    else $error("sleep expiry did not wake");
  a_flag_set: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_DEV_RESET |=> rflag_r)
    else $error("reset flag not set");
  a_switch_keep: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_CLK_SWITCH && wd_en && !tick && !clr_cmd && st_r == ST_RUN && !early
    |=> cnt_r == $past(cnt_r))
    else $error("clock switch disturbed counter");
  a_sleep_src: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    sleep && wd_en && st_r == ST_RUN && !low_power_rc_clock_tick && !clr_cmd |=> cnt_r == $past(cnt_r))
    else $error("sleep counter advanced without rc tick");
  a_pulse_len: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $rose(O_DEV_RESET) |-> O_DEV_RESET [*4] ##1 !O_DEV_RESET)
    else $error("device reset pulse length wrong");
endmodule

// File: rtl/wwdt_pkg.sv
// Package: register map, fields, reset values and timing for the windowed watchdog
package wwdt_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] PERIOD_OFS   = 8'h04;
  localparam logic [7:0] CLEAR_OFS    = 8'h08;
  localparam logic [7:0] RCAUSE_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] MASK_OFS     = 8'h14;
  localparam logic [7:0] COUNT_OFS    = 8'h18;
  // Control fields
  localparam int CTRL_SW_EN_BIT  = 0;
  localparam int CTRL_WIN_BIT    = 1;
  localparam int CTRL_CLKSEL_BIT = 2;
  localparam int CTRL_WINSEL_LSB = 4;
  localparam int WINSEL_W        = 2;
  // Period fields: run postscaler low, sleep postscaler high
  localparam int PS_W            = 5;
  localparam int PERIOD_RUN_LSB  = 0;
  localparam int PERIOD_SLP_LSB  = 8;
  // Clear key written to the clear register
  localparam logic [15:0] CLEAR_KEY = 16'h5743;
  // Reset-cause, status and mask fields
  localparam int RCAUSE_WDT_BIT  = 0;
  localparam int EV_EXPIRE_BIT   = 0;
  localparam int EV_EARLY_BIT    = 1;
  localparam int EV_WAKE_BIT     = 2;
  localparam int EV_W            = 3;
  // Reset values
  localparam logic [7:0]        CTRL_RST   = 8'h00;
  localparam logic [PS_W-1:0]   PS_RUN_RST = 5'h0A;
  localparam logic [PS_W-1:0]   PS_SLP_RST = 5'h0A;
  localparam logic [EV_W-1:0]   MASK_RST   = 3'h0;
  // Counter width: postscaler up to 2^31 ticks
  localparam int CNT_W = 32;
  // Device reset pulse length in cycles
  localparam int RST_PULSE_NS  = 100;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Main states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_FIRE  = 3'b010,
    ST_HOLD  = 3'b100
  } wwdt_state_t;
endpackage

// File: rtl/wwdt_tick_sync.sv
// Two-flop synchroniser and rising-edge detector for a watchdog clock source
module wwdt_tick_sync
  import wwdt_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Asynchronous clock source and its edge pulse
  input  wire logic i_src,
  output logic      o_tick
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic meta_nxt;
  logic sync_nxt;
  logic last_nxt;
  logic tick_nxt;
  logic tick_r;

  always_comb begin
    meta_nxt = i_src;
    sync_nxt = meta_r;
    last_nxt = sync_r;
    tick_nxt = sync_r & ~last_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;
endmodule

// File: dv/wwdt_tb_top.sv
// Self-checking bench for the windowed watchdog
module wwdt_tb_top
  import wwdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        low_power_rc_clock = 0;
  logic        uclk = 0;
  logic        cfg_en = 0;
  logic        cfg_win = 0;
  logic        sleep = 0;
  logic        csw = 0;
  logic        rd_ph = 0;
  logic [2:0]  lp_n = 0;
  logic [1:0]  u_n = 0;
  logic [31:0] r = 0;
  logic [31:0] exp_q[$];
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         dev_rst;
  wire         wake;
  wire         irq;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n = 0;

  wwdt_top i_wwdt_top (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(1'b1), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
    .I_LOW_POWER_RC_CLOCK_CLK(low_power_rc_clock), .I_USER_CLK(uclk), .I_CFG_EN(cfg_en), .I_CFG_WIN(cfg_win),
    .I_SLEEP(sleep), .I_CLK_SWITCH(csw), .O_DEV_RESET(dev_rst), .O_WAKE(wake),
    .O_IRQ(irq)
  );

  always #12.5 clk = ~clk;

  // Slow RC clock (16 cycles) and fast user clock (4 cycles) tell the sources apart
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    lp_n <= lp_n + 3'h1;
    u_n  <= u_n + 2'h1;
    if (lp_n == 3'h7) low_power_rc_clock <= ~low_power_rc_clock;
    if (u_n[0]) uclk <= ~uclk;
  end

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (cyc == 20000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end

  // Read data is taken at the edge that closes the data phase
  always @(posedge clk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      chk(hrdata === exp_q.pop_front(), "read data");
      chk(hresp === 1'b0, "response not okay");
    end
  end

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    if (!wr) exp_q.push_back(d);
    rd_ph  <= ~wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_ph  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, e);
  endtask

  // Waits a bounded time for a reset or wake event and checks when it came
  task automatic wait_ev(input bit w, input int lo, input int hi, input string m);
    n = 0;
    while (((w ? wake : dev_rst) !== 1'b1) && n < hi) begin
      @(posedge clk);
      n++;
    end
    chk(n >= lo && n < hi, m);
  endtask

  initial begin
    void'($urandom(72));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL_OFS, {24'h0, CTRL_RST});
    rd(PERIOD_OFS, {19'h0, PS_SLP_RST, 3'h0, PS_RUN_RST});
    rd(RCAUSE_OFS, 32'h0);
    rd(STATUS_OFS, 32'h0);
    rd(MASK_OFS, {29'h0, MASK_RST});
    rd(8'h1C, 32'h0);
    r = $urandom;
    wr(MASK_OFS, r);
    rd(MASK_OFS, {29'h0, r[2:0]});
    repeat (100) @(posedge clk);
    rd(COUNT_OFS, 32'h0);
    wr(PERIOD_OFS, 32'h0000_0302);
    wr(MASK_OFS, 32'h1);
    // Clock switch held active across the whole count
    wr(CLEAR_OFS, {16'h0, CLEAR_KEY});
    @(posedge clk);
    csw    <= 1'b1;
    cfg_en <= 1'b1;
    wait_ev(0, 30, 150, "run expiry on rc clock");
    csw    <= 1'b0;
    cfg_en <= 1'b0;
    n = 0;
    while (dev_rst === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n == RST_PULSE_CYC, "reset pulse length");
    chk(irq === 1'b1, "irq after expiry");
    rd(RCAUSE_OFS, 32'h1);
    rd(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "irq after status read");
    wr(RCAUSE_OFS, 32'h1);
    rd(RCAUSE_OFS, 32'h0);
    // Clears well inside the period keep the device out of reset
    wr(CTRL_OFS, 32'h1);
    repeat (10) begin
      repeat (20) @(posedge clk);
      wr(CLEAR_OFS, {16'h0, CLEAR_KEY});
    end
    rd(RCAUSE_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0);
    // Windowed by config: clear at count zero is too early
    @(posedge clk);
    cfg_win <= 1'b1;
    wr(CTRL_OFS, 32'h1);
    wr(CLEAR_OFS, {16'h0, CLEAR_KEY});
    wait_ev(0, 0, 10, "early clear reset");
    wr(CTRL_OFS, 32'h0);
    cfg_win <= 1'b0;
    rd(STATUS_OFS, 32'h2);
    chk(irq === 1'b0, "masked early event");
    wr(RCAUSE_OFS, 32'h1);
    // Sleep with user clock selected still counts rc ticks on the sleep period
    sleep <= 1'b1;
    wr(CTRL_OFS, 32'h5);
    wait_ev(1, 90, 300, "sleep wake on rc clock");
    rd(RCAUSE_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0);
    sleep <= 1'b0;
    wr(CTRL_OFS, 32'h5);
    wait_ev(0, 0, 26, "run expiry on user clock");
    wr(CTRL_OFS, 32'h0);
    tally_and_finish();
  end
endmodule
